// file: core/sbt_timer.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`default_nettype none
// Notes on behaviour
// - count up through 16 bits, wrapping from all-ones to zero
// - wrap latches overflow flag; interrupt only when its enable is set
// - control bit 0 runs the counter; clear holds the value
// - bit 1 picks instruction clock or external rising edges
// - timer, synchronous counter and asynchronous counter modes
// - external source: bit 2 set skips sync, clear syncs; ignored internally
// - bits 5:4 choose prescale 1:1, 1:2, 1:4 or 1:8
// - bit 3 enables the low-power oscillator, clear shuts it off
// - oscillator enabled forces both crystal pins to inputs
// - oscillator and asynchronous counting keep going during sleep
// - bit 7 picks one 16-bit access or two byte accesses
// - bit 6 always reads zero
// - capture/compare reset input clears the count
// - wide mode: low read copies high byte to buffer; low write loads it
// - wide mode: buffer writes keep prescaler, low writes clear it
// - capture/compare reset sets no flag; a coinciding write wins
module sbt_timer
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // count pins and crystal pins
    input wire logic ext_count_pin,
    input wire logic osc_in_pin,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe,
    // port direction override
    input wire logic [1:0] port_c_direction,
    output logic [1:0] pin_dir_eff,
    // system
    input wire logic sleep,
    input wire logic ccp_reset
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [15:0] cnt;
        logic [7:0] hbuf;
        logic flag;
        logic mask;
        logic [1:0] div_q;
        logic sync_d;
        logic rdy;
        logic err;
        logic [31:0] rdata;
        logic irq;
        logic osc_o;
        logic osc_oe;
        logic [1:0] dir;
    } sbt_top_s;

    sbt_top_s st;
    sbt_top_s nx;

    logic access;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_low;
    logic hit_high;
    logic hit_flag;
    logic hit_mask;
    logic wide;
    logic osc_en;
    logic wr_low;
    logic wr_high;
    logic cnt_wr;
    logic ps_clr;
    logic int_tick;
    logic ext_rise;
    logic src_tick;
    logic ps_tick;
    logic ovf;
    logic pin_rise;
    logic osc_rise;
    logic osc_lvl;

    // bus decode; effects land on the first access cycle, pready follows
    assign access = psel & penable & ~st.rdy;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_low = (paddr == OFS_LOW);
    assign hit_high = (paddr == OFS_HIGH);
    assign hit_flag = (paddr == OFS_FLAG);
    assign hit_mask = (paddr == OFS_MASK);
    assign wide = st.ctl[CTL_WIDE];
    assign osc_en = st.ctl[CTL_OSC];
    assign wr_low = wr & hit_low;
    assign wr_high = wr & hit_high;

    // byte mode writes the high byte directly, wide mode only the buffer
    assign cnt_wr = wr_low | (wr_high & ~wide);
    assign ps_clr = cnt_wr;

    // instruction clock stops in sleep, like the core clock would
    assign int_tick = (st.div_q == DIV_LAST) & ~sleep;

    // enabled oscillator replaces the external pin as count source
    assign ext_rise = osc_en ? osc_rise : pin_rise;

    // mode select: timer, synced counter, or unsynced counter
    always_comb begin
        if (!st.ctl[CTL_SRC]) begin
            src_tick = int_tick;
        end else if (st.ctl[CTL_BYP]) begin
            src_tick = ext_rise;
        end else begin
            src_tick = st.sync_d;
        end
    end

    // next state
    always_comb begin
        nx = st;
        ovf = 1'b0;
        nx.div_q = (st.div_q == DIV_LAST) ? 2'h0 : 2'(st.div_q + 2'h1);
        // synced path is one more core-domain stage, halted in sleep
        nx.sync_d = ext_rise & ~sleep;
        // control register, bit 6 never stored
        if (wr & hit_ctrl) begin
            nx.ctl = pwdata[7:0] & CTL_WMASK;
        end
        // count: write beats capture/compare reset beats increment
        if (wr_low) begin
            nx.cnt = wide ? {st.hbuf, pwdata[7:0]} : {st.cnt[15:8], pwdata[7:0]};
        end else if (wr_high && !wide) begin
            nx.cnt = {pwdata[7:0], st.cnt[7:0]};
        end else if (ccp_reset) begin
            nx.cnt = CNT_RST;
        end else if (ps_tick) begin
            nx.cnt = 16'(st.cnt + 16'h0001);
            ovf = (st.cnt == CNT_MAX);
        end
        // high byte buffer
        if (wr_high && wide) begin
            nx.hbuf = pwdata[7:0];
        end else if (rd && hit_low && wide) begin
            nx.hbuf = st.cnt[15:8];
        end
        // sticky flag, a new overflow beats the write-one clear
        nx.flag = (st.flag & ~(wr & hit_flag & pwdata[0])) | ovf;
        if (wr & hit_mask) begin
            nx.mask = pwdata[0];
        end
        nx.irq = nx.flag & nx.mask;
        // read data, zero when not a read
        nx.rdata = 32'h0000_0000;
        if (rd) begin
            if (hit_ctrl) begin
                nx.rdata[7:0] = st.ctl & CTL_WMASK;
            end else if (hit_low) begin
                nx.rdata[7:0] = st.cnt[7:0];
            end else if (hit_high) begin
                nx.rdata[7:0] = wide ? st.hbuf : st.cnt[15:8];
            end else if (hit_flag) begin
                nx.rdata[0] = st.flag;
            end else if (hit_mask) begin
                nx.rdata[0] = st.mask;
            end
        end
        nx.rdy = access;
        nx.err = access & ~(hit_ctrl | hit_low | hit_high | hit_flag | hit_mask);
        // amplifier inverts the sampled crystal input; off means no drive
        nx.osc_o = osc_en & ~osc_lvl;
        nx.osc_oe = osc_en;
        // oscillator logic ignores sleep so it keeps running
        nx.dir = osc_en ? 2'h3 : port_c_direction;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctl <= CTL_RST;
            st.cnt <= CNT_RST;
            st.hbuf <= BUF_RST;
        end else begin
            st <= nx;
        end
    end

    // external pin sampler
    sbt_edge_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_count_pin),
        .level(),
        .rise(pin_rise)
    );

    // crystal input sampler, works in sleep too
    sbt_edge_sync u_osc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(osc_in_pin),
        .level(osc_lvl),
        .rise(osc_rise)
    );

    // prescaler only sees ticks while the counter runs
    sbt_prescaler #(
        .W(PS_W)
    ) u_ps (
        .pclk(pclk),
        .presetn(presetn),
        .tick(src_tick & st.ctl[CTL_RUN]),
        .clr(ps_clr),
        .sel(st.ctl[CTL_PS_HI:CTL_PS_LO]),
        .tick_o(ps_tick)
    );

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign irq = st.irq;
    assign osc_out_pin_o = st.osc_o;
    assign osc_out_pin_oe = st.osc_oe;
    assign pin_dir_eff = st.dir;

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (ps_tick && !cnt_wr && !ccp_reset && st.cnt == CNT_MAX) |=> (st.cnt == CNT_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        (ps_tick && !cnt_wr && !ccp_reset && st.cnt == CNT_MAX) |=> st.flag;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set on wrap");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (st.flag && st.mask) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked flag without interrupt");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!st.ctl[CTL_RUN] && !cnt_wr && !ccp_reset) |=> $stable(st.cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped counter changed");

    property p_int_rate;
        @(posedge pclk) disable iff (!presetn)
        (!st.ctl[CTL_SRC] && src_tick) |-> (st.div_q == DIV_LAST);
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("timer tick off instruction cycle");

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        (st.ctl[CTL_SRC] && !st.ctl[CTL_BYP] && src_tick) |-> $past(ext_rise);
    endproperty
    a_sync: assert property (p_sync) else $error("synced tick without earlier edge");

    property p_bit6;
        @(posedge pclk) disable iff (!presetn)
        (rd && hit_ctrl) |=> (pready && !prdata[6]);
    endproperty
    a_bit6: assert property (p_bit6) else $error("control bit 6 read as one");

    property p_ccp;
        @(posedge pclk) disable iff (!presetn)
        (ccp_reset && !cnt_wr && !(wr & hit_flag)) |=> (st.cnt == CNT_RST && st.flag == $past(st.flag));
    endproperty
    a_ccp: assert property (p_ccp) else $error("ccp reset failed or set flag");

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        (wr_low && ccp_reset) |=> (st.cnt[7:0] == $past(pwdata[7:0]));
    endproperty
    a_prio: assert property (p_prio) else $error("write lost to ccp reset");

    property p_buf;
        @(posedge pclk) disable iff (!presetn)
        (rd && hit_low && wide) |=> (st.hbuf == $past(st.cnt[15:8]));
    endproperty
    a_buf: assert property (p_buf) else $error("buffer not loaded on low read");

    property p_hi_noclr;
        @(posedge pclk) disable iff (!presetn)
        (wr_high && wide) |-> !ps_clr;
    endproperty
    a_hi_noclr: assert property (p_hi_noclr) else $error("buffer write cleared prescaler");

    property p_osc_dir;
        @(posedge pclk) disable iff (!presetn)
        osc_en |=> (pin_dir_eff == 2'h3);
    endproperty
    a_osc_dir: assert property (p_osc_dir) else $error("crystal pins not inputs");

    property p_osc_off;
        @(posedge pclk) disable iff (!presetn)
        !osc_en |=> (!osc_out_pin_oe && !osc_out_pin_o);
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator drives while off");
endmodule
`default_nettype wire

// file: shared/sbt_pkg.sv
`default_nettype none
package sbt_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_LOW = 12'h004;
    localparam logic [11:0] OFS_HIGH = 12'h008;
    localparam logic [11:0] OFS_FLAG = 12'h00C;
    localparam logic [11:0] OFS_MASK = 12'h010;
    // counter_control_reg field positions
    localparam int CTL_RUN = 0;
    localparam int CTL_SRC = 1;
    localparam int CTL_BYP = 2;
    localparam int CTL_OSC = 3;
    localparam int CTL_PS_LO = 4;
    localparam int CTL_PS_HI = 5;
    localparam int CTL_WIDE = 7;
    // values after reset and write masks
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hBF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] BUF_RST = 8'h00;
    // core clock cycles per instruction cycle
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);
    // prescaler counter width, enough for 1:8
    localparam int PS_W = 3;
endpackage
`default_nettype wire

// file: core/sbt_edge_sync.sv
`default_nettype none
module sbt_edge_sync
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pin and its clean view
    input wire logic pin,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } sbt_sync_s;

    sbt_sync_s st;
    sbt_sync_s nx;

    // level only moves once stages two and three agree
    always_comb begin
        nx = st;
        nx.s1 = pin;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        if (st.s2 == st.s3) begin
            nx.lvl = st.s2;
        end
        nx.rise = nx.lvl & ~st.lvl;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign level = st.lvl;
    assign rise = st.rise;
endmodule
`default_nettype wire

// file: core/sbt_prescaler.sv
`default_nettype none
module sbt_prescaler
    import sbt_pkg::*;
#(
    parameter int W = PS_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // input ticks, clear and ratio
    input wire logic tick,
    input wire logic clr,
    input wire logic [1:0] sel,
    // one pulse per ratio ticks
    output logic tick_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } sbt_ps_s;

    sbt_ps_s st;
    sbt_ps_s nx;
    logic [W-1:0] mask;

    // ratio mask and divided tick
    always_comb begin
        unique case (sel)
            2'h0: mask = W'(0);
            2'h1: mask = W'(1);
            2'h2: mask = W'(3);
            2'h3: mask = W'(7);
        endcase
        tick_o = tick & ((st.cnt & mask) == mask);
        nx = st;
        if (clr) begin
            nx.cnt = '0;
        end else if (tick) begin
            nx.cnt = W'(st.cnt + W'(1));
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    property p_ratio8;
        @(posedge pclk) disable iff (!presetn)
        (sel == 2'h3 && tick_o) |-> (st.cnt == W'(7));
    endproperty
    a_ratio8: assert property (p_ratio8) else $error("1:8 tick not on eighth count");

    property p_clr;
        @(posedge pclk) disable iff (!presetn)
        clr |=> (st.cnt == '0);
    endproperty
    a_clr: assert property (p_clr) else $error("prescaler not cleared");
endmodule
`default_nettype wire

// file: tb/sbt_clk_src.sv
`default_nettype none
module sbt_clk_src (
    // core clock and crystal pad state
    input wire logic pclk,
    input wire logic osc_oe,
    // count lines into the device
    output logic ext_pin,
    output logic osc_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // both lines rest low between bursts, like a stopped crystal
    initial begin
        ext_pin = 1'b0;
        osc_in = 1'b0;
    end

    // n rising edges, 13 core cycles each so the 3-flop sampler sees every one
    // the crystal line is used only while the device runs its oscillator
    task automatic edges(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (osc_oe) begin
                osc_in <= 1'b1;
            end else begin
                ext_pin <= 1'b1;
            end
            repeat (6) @(posedge pclk);
            osc_in <= 1'b0;
            ext_pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        // margin for the synchroniser latency
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb
    import sbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic sleep;
    logic ccp_reset;
    logic [1:0] port_c_direction;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, osc_out_pin_o, osc_out_pin_oe;
    wire logic [1:0] pin_dir_eff;
    wire logic ext_count_pin, osc_in_pin;
    int seed = 32'hf688;
    int miscompares = 0;
    int total_checks = 0;
    logic [17:0] q[$];
    logic [11:0] ofs[5] = '{OFS_CTRL, OFS_LOW, OFS_HIGH, OFS_FLAG, OFS_MASK};

    always #10 pclk = ~pclk;

    sbt_timer i_sbt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .ext_count_pin(ext_count_pin), .osc_in_pin(osc_in_pin), .osc_out_pin_o(osc_out_pin_o),
        .osc_out_pin_oe(osc_out_pin_oe), .port_c_direction(port_c_direction), .pin_dir_eff(pin_dir_eff),
        .sleep(sleep), .ccp_reset(ccp_reset));

    sbt_clk_src i_sbt_clk_src (.pclk(pclk), .osc_oe(osc_out_pin_oe), .ext_pin(ext_count_pin),
        .osc_in(osc_in_pin));

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; a read notes {pslverr, data} bounds for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [8:0] lo, input logic [8:0] hi);
        int n;
        if (!w) begin
            q.push_back({lo, hi});
        end
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            test_done;
        end
        // idle edge, so a following call never drives psel twice at one instant
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 9'h000, 9'h000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 8'h00, {1'b0, d}, {1'b0, d});
    endtask

    // monitor: every completed read takes the oldest note; unequal bounds mean a window
    always @(posedge pclk) begin
        logic [17:0] e;
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
            e = q.pop_front();
            if (e[17:9] == e[8:0]) begin
                check({pslverr, prdata[7:0]}, e[8:0]);
            end else begin
                check(9'({pslverr, prdata[7:0]} >= e[17:9] && {pslverr, prdata[7:0]} <= e[8:0]), 9'h001);
            end
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        test_done;
    end

    initial begin
        logic [7:0] c;
        logic [7:0] h;
        logic [1:0] r;
        // idle bus and side inputs while reset is held
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
        sleep <= 1'b0;
        ccp_reset <= 1'b0;
        port_c_direction <= 2'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, reserved bit, unmapped slot
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        wr(12'h014, 8'hA5);
        apb(1'b0, 12'h014, 8'h00, 9'h100, 9'h100);
        wr(OFS_CTRL, 8'hFF);
        rd(OFS_CTRL, 8'hBF);
        // timer mode: one count per four core cycles, none in sleep
        wr(OFS_CTRL, 8'h00);
        wr(OFS_LOW, 8'h00);
        wr(OFS_CTRL, 8'h01);
        repeat (400) @(posedge pclk);
        wr(OFS_CTRL, 8'h00);
        apb(1'b0, OFS_LOW, 8'h00, 9'd99, 9'd102);
        sleep <= 1'b1;
        wr(OFS_LOW, 8'h00);
        wr(OFS_CTRL, 8'h01);
        repeat (40) @(posedge pclk);
        wr(OFS_CTRL, 8'h00);
        sleep <= 1'b0;
        rd(OFS_LOW, 8'h00);
        // external edges through every prescale ratio; last one unsynchronised
        for (int p = 0; p < 4; p++) begin
            c = 8'(2 + p * 16 + (p == 3 ? 4 : 0));
            wr(OFS_CTRL, c);
            wr(OFS_LOW, 8'h00);
            wr(OFS_HIGH, 8'h00);
            wr(OFS_CTRL, c | 8'h01);
            i_sbt_clk_src.edges(8);
            rd(OFS_LOW, 8'(8 >> p));
        end
        wr(OFS_CTRL, c);
        i_sbt_clk_src.edges(2);
        rd(OFS_LOW, 8'h01);
        // wrap from all-ones, flag, mask and clear
        wr(OFS_CTRL, 8'h02);
        wr(OFS_HIGH, 8'hFF);
        wr(OFS_LOW, 8'hFF);
        wr(OFS_MASK, 8'h01);
        wr(OFS_CTRL, 8'h03);
        i_sbt_clk_src.edges(1);
        @(negedge pclk);
        check(9'(irq), 9'h001);
        @(posedge pclk);
        rd(OFS_FLAG, 8'h01);
        rd(OFS_LOW, 8'h00);
        rd(OFS_HIGH, 8'h00);
        wr(OFS_MASK, 8'h00);
        @(negedge pclk);
        check(9'(irq), 9'h000);
        @(posedge pclk);
        wr(OFS_FLAG, 8'h01);
        wr(OFS_MASK, 8'h01);
        @(negedge pclk);
        check(9'(irq), 9'h000);
        @(posedge pclk);
        rd(OFS_FLAG, 8'h00);
        // capture/compare clear sets no flag
        i_sbt_clk_src.edges(3);
        ccp_reset <= 1'b1;
        @(posedge pclk);
        ccp_reset <= 1'b0;
        rd(OFS_LOW, 8'h00);
        rd(OFS_FLAG, 8'h00);
        // capture/compare clear lands on the write's own edge; the write must win
        fork
            wr(OFS_LOW, 8'h5A);
            begin
                @(posedge pclk);
                ccp_reset <= 1'b1;
                @(posedge pclk);
                ccp_reset <= 1'b0;
            end
        join
        rd(OFS_LOW, 8'h5A);
        // wide access: buffered high byte
        h = 8'($random(seed));
        wr(OFS_CTRL, 8'h83);
        wr(OFS_HIGH, h);
        wr(OFS_LOW, 8'hFF);
        rd(OFS_LOW, 8'hFF);
        i_sbt_clk_src.edges(1);
        rd(OFS_HIGH, h);
        rd(OFS_LOW, 8'h00);
        rd(OFS_HIGH, h + 8'h01);
        // buffer write keeps the half-counted prescaler
        wr(OFS_CTRL, 8'h93);
        wr(OFS_LOW, 8'h00);
        i_sbt_clk_src.edges(1);
        wr(OFS_HIGH, 8'h00);
        i_sbt_clk_src.edges(1);
        rd(OFS_LOW, 8'h01);
        // crystal: pads forced to inputs, counting on through sleep when unsynchronised
        r = 2'($random(seed));
        port_c_direction <= r;
        wr(OFS_CTRL, 8'h0E);
        wr(OFS_LOW, 8'h00);
        @(negedge pclk);
        check({5'h00, osc_out_pin_o, osc_out_pin_oe, pin_dir_eff}, 9'h00F);
        @(posedge pclk);
        repeat (50) @(posedge pclk);
        sleep <= 1'b1;
        wr(OFS_CTRL, 8'h0F);
        i_sbt_clk_src.edges(4);
        rd(OFS_LOW, 8'h04);
        wr(OFS_CTRL, 8'h0B);
        i_sbt_clk_src.edges(2);
        rd(OFS_LOW, 8'h04);
        sleep <= 1'b0;
        wr(OFS_CTRL, 8'h00);
        @(negedge pclk);
        check({5'h00, osc_out_pin_o, osc_out_pin_oe, pin_dir_eff}, {7'h00, r});
        @(posedge pclk);
        test_done;
    end
endmodule
`default_nettype wire
